// ===== src/sbwc_map.vh
// Constants for the store buffer and write-combining unit
`ifndef SBWC_MAP_VH
`define SBWC_MAP_VH
// Memory type codes
`define MT_UNCACHED 3'h0
`define MT_COMBINING 3'h1
`define MT_COH_COMBINING 3'h2
`define MT_WRITE_PROTECT 3'h3
`define MT_WRITE_THROUGH 3'h4
`define MT_WRITEBACK 3'h5
// Operation codes on the request port
`define OP_LOAD 3'h0
`define OP_STORE 3'h1
`define OP_STREAM 3'h2
`define OP_ATOMIC 3'h3
`define OP_PORT_IO 3'h4
`define OP_STORE_FENCE 3'h5
`define OP_FULL_FENCE 3'h6
`define OP_LOAD_FENCE 3'h7
// Queue and line sizes
`define SB_DEPTH 8
`define WC_LINE_BYTES 64
`define WC_LINE_SHIFT 6
`endif

// ===== src/combine_buffer.v
// Write-combining buffer with per-byte valid mask
`default_nettype none
`include "sbwc_map.vh"
module combine_buffer #(
	parameter AW = 32,
	parameter LSH = `WC_LINE_SHIFT
)(
	input wire clk,
	input wire rstn,
	input wire wr,
	input wire [AW-1:0] wr_addr,
	input wire [7:0] wr_data,
	input wire clear,
	input wire [AW-1:0] probe_addr,
	output wire active,
	output wire in_range,
	output wire probe_hit,
	output wire [AW-LSH-1:0] line,
	output wire [(8<<LSH)-1:0] data,
	output wire [(1<<LSH)-1:0] mask
);
	// ==========================================
	// Storage
	localparam NB = 1 << LSH;
	reg active_reg; // Range open
	reg [AW-LSH-1:0] line_reg; // Aligned range base
	reg [8*NB-1:0] data_reg; // Combined bytes
	reg [NB-1:0] mask_reg; // Bytes written since open
	wire [LSH-1:0] sel = wr_addr[LSH-1:0];
	assign active = active_reg;
	assign in_range = active_reg && (wr_addr[AW-1:LSH] == line_reg);
	assign probe_hit = active_reg && (probe_addr[AW-1:LSH] == line_reg);
	assign line = line_reg;
	assign data = data_reg;
	assign mask = mask_reg;
	// Open, merge, or clear; the owner copies the line out before it clears
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			active_reg <= 1'b0;
			line_reg <= {(AW-LSH){1'b0}};
			data_reg <= {(8*NB){1'b0}};
			mask_reg <= {NB{1'b0}};
		end
		else if (clear)
		begin
			// A write in the same cycle opens the next range at once
			active_reg <= wr;
			line_reg <= wr_addr[AW-1:LSH];
			mask_reg <= {NB{1'b0}};
			if (wr)
			begin
				data_reg[sel*8 +: 8] <= wr_data;
				mask_reg[sel] <= 1'b1;
			end
		end
		else if (wr)
		begin
			if (!active_reg)
			begin
				// Size and alignment equal the buffer size
				active_reg <= 1'b1;
				line_reg <= wr_addr[AW-1:LSH];
			end
			// Any byte in range merges; later writes overwrite
			data_reg[sel*8 +: 8] <= wr_data;
			mask_reg[sel] <= 1'b1;
		end
	end
endmodule // combine_buffer
`default_nettype wire

// ===== src/store_buffer_write_combining.v
// Store buffer with write-combining buffer, in-order drain and flush control
`default_nettype none
`include "sbwc_map.vh"
module store_buffer_write_combining #(
	parameter AW = 32,
	parameter DEPTH = `SB_DEPTH,
	parameter PW = 3
)(
	input wire clk,
	input wire rstn,
	input wire req_valid,
	input wire [2:0] req_op,
	input wire [2:0] req_type,
	input wire [AW-1:0] req_addr,
	input wire [7:0] req_wdata,
	input wire serialize,
	input wire mem_ready,
	input wire [7:0] mem_rdata,
	output reg req_ready,
	output reg load_done,
	output reg [7:0] load_data,
	output reg fetch_allow,
	output reg mem_valid,
	output reg mem_write,
	output reg mem_to_main,
	output reg [2:0] mem_type,
	output reg [AW-1:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg line_valid,
	output reg [AW-1:0] line_addr,
	output reg [8*`WC_LINE_BYTES-1:0] line_data,
	output reg [`WC_LINE_BYTES-1:0] line_mask
);
	// ==========================================
	// Decode helpers
	function is_comb;
		input [2:0] t;
		is_comb = (t == `MT_COMBINING) || (t == `MT_COH_COMBINING);
	endfunction
	// ==========================================
	// State machine, one-hot
	localparam S_IDLE = 5'h01; // Accepting requests
	localparam S_DRAIN = 5'h02; // Emptying both buffers before an ordered op
	localparam S_ACCESS = 5'h04; // Direct memory access in flight
	localparam S_LINE = 5'h08; // Combining line going to main memory
	localparam S_WAIT = 5'h10; // Waiting for the direct access answer
	reg [4:0] state_reg;
	reg [4:0] state_next;
	// ==========================================
	// Store queue in flip-flops, indexed by pointer
	reg [AW-1:0] q_addr [0:DEPTH-1];
	reg [7:0] q_data [0:DEPTH-1];
	reg [2:0] q_type [0:DEPTH-1];
	reg [PW-1:0] head_reg; // Oldest entry
	reg [PW-1:0] tail_reg; // Next free entry
	reg [PW:0] count_reg; // Occupancy
	reg retire_busy_reg; // Head write presented to memory
	wire q_empty = (count_reg == {(PW+1){1'b0}});
	wire q_full = (count_reg == DEPTH[PW:0]);
	// ==========================================
	// Combining buffer
	reg wc_wr;
	reg wc_clear;
	wire wc_active;
	wire wc_in_range;
	wire wc_probe_hit;
	wire [AW-`WC_LINE_SHIFT-1:0] wc_line;
	wire [8*`WC_LINE_BYTES-1:0] wc_data;
	wire [`WC_LINE_BYTES-1:0] wc_mask;
	combine_buffer #(.AW(AW), .LSH(`WC_LINE_SHIFT)) u_wc (
		.clk(clk),
		.rstn(rstn),
		.wr(wc_wr),
		.wr_addr(req_addr),
		.wr_data(req_wdata),
		.clear(wc_clear),
		.probe_addr(req_addr),
		.active(wc_active),
		.in_range(wc_in_range),
		.probe_hit(wc_probe_hit),
		.line(wc_line),
		.data(wc_data),
		.mask(wc_mask)
	);
	// ==========================================
	// Forwarding lookup: youngest matching queued store wins
	reg fwd_hit;
	reg [7:0] fwd_data;
	reg [PW-1:0] idx;
	integer k;
	always @*
	begin
		fwd_hit = 1'b0;
		fwd_data = 8'h00;
		idx = head_reg;
		for (k = 0; k < DEPTH; k = k + 1)
		begin
			if (k < count_reg && q_addr[idx] == req_addr)
			begin
				fwd_hit = 1'b1;
				fwd_data = q_data[idx];
			end
			idx = idx + 1'b1;
		end
	end
	// ==========================================
	// Request classification
	wire is_load = (req_op == `OP_LOAD);
	wire is_wr = (req_op == `OP_STORE) || (req_op == `OP_STREAM);
	// Streaming stores use the combining path unless uncached
	wire wr_comb = is_wr && (is_comb(req_type) || req_op == `OP_STREAM);
	// Everything that must wait for both buffers empty
	wire ordered = (req_op == `OP_ATOMIC) || (req_op == `OP_PORT_IO) ||
		(req_op == `OP_FULL_FENCE) || (req_op == `OP_STORE_FENCE) ||
		(req_type == `MT_UNCACHED && (is_load || is_wr));
	wire all_empty = q_empty && !wc_active && !retire_busy_reg;
	// Non-combining write in range, or combining write out of range
	wire wc_conflict = wc_active && ((is_wr && !wr_comb && wc_probe_hit) ||
		(wr_comb && !wc_in_range));
	// Cacheable load may pass stores only if it misses the open combining range
	wire load_now = is_load && req_type != `MT_UNCACHED && !wc_probe_hit;
	// Taken only at an edge where ready was shown, never during a serialize drain
	wire take = req_valid && req_ready && !serialize;
	reg pend_reg; // Held request needs the direct path after drain
	// ==========================================
	// Next state
	always @*
	begin
		state_next = state_reg;
		wc_wr = 1'b0;
		wc_clear = 1'b0;
		case (state_reg)
			S_IDLE:
			begin
				if (serialize && !all_empty)
					state_next = S_DRAIN;
				else if (take)
				begin
					if (ordered)
						state_next = S_DRAIN;
					else if (wc_conflict)
					begin
						// Old line is copied out; a combining write reopens at once
						wc_wr = wr_comb;
						state_next = S_LINE;
					end
					else if (wr_comb)
						wc_wr = 1'b1;
				end
			end
			S_DRAIN:
			begin
				// Queue first, then the line, so combining data never races
				if (q_empty && !retire_busy_reg)
				begin
					if (wc_active)
						state_next = S_LINE;
					else if (pend_reg)
						state_next = S_ACCESS;
					else
						state_next = S_IDLE;
				end
			end
			S_LINE:
			begin
				if (mem_ready)
					state_next = pend_reg ? S_ACCESS : S_IDLE;
			end
			S_ACCESS:
				state_next = S_WAIT;
			S_WAIT:
			begin
				if (mem_ready)
					state_next = S_IDLE;
			end
			default:
				state_next = S_IDLE;
		endcase
		// Flush captures the line on entry, so the buffer may reopen at once
		wc_clear = (state_next == S_LINE) && (state_reg != S_LINE);
	end
	// ==========================================
	// Queue push/pop and memory port drive
	// A plain store that hits the open range is queued while the line leaves
	wire push = (state_reg == S_IDLE) && take && !ordered && is_wr && !wr_comb && !q_full;
	// The line and the head store may be answered by the same ready
	wire pop = retire_busy_reg && mem_ready && state_reg != S_WAIT && state_reg != S_ACCESS;
	wire dir_load = (state_reg == S_IDLE) && take && !ordered && !wc_conflict && load_now;
	wire [PW:0] count_next = count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
	reg [2:0] held_op; // Ordered request kept apart from the store port
	reg [AW-1:0] held_addr;
	reg [7:0] held_data;
	reg [2:0] held_type;
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= S_IDLE;
			head_reg <= {PW{1'b0}};
			tail_reg <= {PW{1'b0}};
			count_reg <= {(PW+1){1'b0}};
			retire_busy_reg <= 1'b0;
			pend_reg <= 1'b0;
			held_op <= 3'h0;
			held_addr <= {AW{1'b0}};
			held_data <= 8'h00;
			held_type <= 3'h0;
			req_ready <= 1'b0;
			load_done <= 1'b0;
			load_data <= 8'h00;
			fetch_allow <= 1'b0;
			mem_valid <= 1'b0;
			mem_write <= 1'b0;
			mem_to_main <= 1'b0;
			mem_type <= 3'h0;
			mem_addr <= {AW{1'b0}};
			mem_wdata <= 8'h00;
			line_valid <= 1'b0;
			line_addr <= {AW{1'b0}};
			line_data <= {(8*`WC_LINE_BYTES){1'b0}};
			line_mask <= {`WC_LINE_BYTES{1'b0}};
		end
		else
		begin
			state_reg <= state_next;
			load_done <= 1'b0;
			// Ready looks at the occupancy after this edge, so a full queue refuses in time
			req_ready <= (state_next == S_IDLE) && (count_next != DEPTH[PW:0]);
			// Fetch only with every store out; a serialize drain ends by raising this
			fetch_allow <= all_empty && state_reg == S_IDLE;
			if (push)
			begin
				q_addr[tail_reg] <= req_addr;
				q_data[tail_reg] <= req_wdata;
				q_type[tail_reg] <= req_type;
				tail_reg <= tail_reg + 1'b1;
			end
			count_reg <= count_next;
			// Cacheable loads outside the open combining range are answered at once and forward; one inside it is never answered
			if (dir_load)
			begin
				load_done <= 1'b1;
				load_data <= fwd_hit ? fwd_data : mem_rdata;
			end
			// Head of queue retires in program order
			if (pop)
			begin
				head_reg <= head_reg + 1'b1;
				retire_busy_reg <= 1'b0;
				mem_valid <= 1'b0;
			end
			else if (!retire_busy_reg && !q_empty && (state_reg == S_IDLE ||
				state_reg == S_DRAIN) && !dir_load)
			begin
				retire_busy_reg <= 1'b1;
				mem_valid <= 1'b1;
				mem_write <= 1'b1;
				mem_to_main <= 1'b0;
				mem_addr <= q_addr[head_reg];
				mem_wdata <= q_data[head_reg];
				mem_type <= q_type[head_reg];
			end
			// Hold the ordered request until the buffers are empty
			if (state_reg == S_IDLE && state_next == S_DRAIN && !serialize)
			begin
				pend_reg <= (req_op == `OP_ATOMIC) || (req_op == `OP_PORT_IO) ||
					(req_type == `MT_UNCACHED);
				// Kept off the port so a store in flight keeps its address
				held_op <= req_op;
				held_addr <= req_addr;
				held_data <= req_wdata;
				held_type <= req_type;
			end
			else if (state_reg == S_IDLE && state_next == S_LINE)
				pend_reg <= 1'b0;
			// Combining line to main memory only, real bytes only
			line_valid <= (state_next == S_LINE);
			if (state_next == S_LINE && state_reg != S_LINE)
			begin
				line_addr <= {wc_line, {`WC_LINE_SHIFT{1'b0}}};
				line_data <= wc_data;
				line_mask <= wc_mask;
			end
			// Atomic and port writes bypass the queue
			if (state_reg == S_ACCESS)
			begin
				mem_valid <= 1'b1;
				mem_write <= held_op != `OP_LOAD;
				// Port and combining traffic never lands in a cache
				mem_to_main <= (held_op == `OP_PORT_IO) || is_comb(held_type);
				mem_addr <= held_addr;
				mem_wdata <= held_data;
				mem_type <= held_type;
			end
			if (state_reg == S_WAIT && mem_ready)
			begin
				mem_valid <= 1'b0;
				pend_reg <= 1'b0;
				load_done <= 1'b1;
				load_data <= mem_rdata;
			end
		end
	end
endmodule // store_buffer_write_combining
`default_nettype wire

// ===== verification/sbwc_checker.sv
// Port assertions for the store buffer and combining unit
`default_nettype none
`include "sbwc_map.vh"
module sbwc_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic mem_ready,
	input wire logic fetch_allow,
	input wire logic load_done,
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic mem_to_main,
	input wire logic [2:0] mem_type,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic line_valid,
	input wire logic [31:0] line_addr,
	input wire logic [63:0] line_mask
);
	// ==========
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_MEM_HOLD: assert property (mem_valid && !mem_ready |=> mem_valid)
		else $error("store dropped before taken");
	AST_MEM_STABLE: assert property (mem_valid && !mem_ready |=> $stable({mem_addr, mem_wdata}))
		else $error("store changed while waiting");
	AST_LINE_HOLD: assert property (line_valid && !mem_ready |=> line_valid)
		else $error("line dropped before taken");
	AST_LINE_STABLE: assert property (line_valid && !mem_ready |=> $stable(line_mask))
		else $error("line mask changed while waiting");
	AST_LINE_ALIGN: assert property (line_valid |-> line_addr[5:0] == 6'h00)
		else $error("line not aligned");
	AST_LINE_MASK: assert property (line_valid |-> line_mask != 64'h0)
		else $error("line flushed with no bytes");
	AST_COMB_MAIN: assert property (mem_valid && mem_type == `MT_COMBINING |-> mem_to_main)
		else $error("combining data sent to cache");
	AST_FETCH_EMPTY: assert property (fetch_allow |-> !mem_valid && !line_valid)
		else $error("fetch allowed with writes pending");
	AST_UC_ALONE: assert property (mem_valid && mem_type == `MT_UNCACHED |-> !line_valid)
		else $error("uncached access beside line flush");
	// Main scenarios seen
	cover property (line_valid && mem_ready);
	cover property (load_done);
	cover property (mem_valid && mem_write && mem_ready);
endmodule // sbwc_checker
bind store_buffer_write_combining sbwc_checker i_chk (.clk(clk), .rstn(rstn),
	.mem_ready(mem_ready), .fetch_allow(fetch_allow), .load_done(load_done),
	.mem_valid(mem_valid), .mem_write(mem_write), .mem_to_main(mem_to_main),
	.mem_type(mem_type), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.line_valid(line_valid), .line_addr(line_addr), .line_mask(line_mask));
`default_nettype wire

// ===== verification/mem_model.sv
// Memory side model: takes each request after one or three waits
`default_nettype none
module mem_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic slow,
	input wire logic mem_valid,
	input wire logic line_valid,
	input wire logic [31:0] mem_addr,
	output logic mem_ready,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_reg; // Cycles waited on the current request
	// ==========
	// Answer: slow mode lets a store sit buffered for a while
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_reg <= 2'h0;
			mem_ready <= 1'b0;
			mem_rdata <= 8'h00;
		end
		else if ((mem_valid || line_valid) && !mem_ready)
		begin
			wait_reg <= wait_reg + 2'h1;
			mem_ready <= wait_reg >= (slow ? 2'h2 : 2'h0);
			mem_rdata <= mem_addr[7:0] ^ 8'hA5;
		end
		else
		begin
			// Data is not held once taken, so stale reuse shows up
			wait_reg <= 2'h0;
			mem_ready <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // mem_model
`default_nettype wire

// ===== verification/store_buffer_write_combining_test.sv
// Self-checking bench for the store buffer and combining unit
`default_nettype none
`include "sbwc_map.vh"
module store_buffer_write_combining_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, req_valid, serialize, mem_ready, slow;
	logic [2:0] req_op, req_type, mem_type;
	logic [31:0] req_addr, mem_addr, line_addr;
	logic [7:0] req_wdata, mem_rdata, load_data, mem_wdata;
	logic req_ready, load_done, fetch_allow, mem_valid, mem_write, mem_to_main, line_valid;
	logic [511:0] line_data, ln_data;
	logic [63:0] line_mask, ln_mask;
	logic [24:0] q[$]; // Transfers taken: line flag, address, data
	int n_errors = 0;
	int checks_done = 0;
	store_buffer_write_combining i_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid),
		.req_op(req_op), .req_type(req_type), .req_addr(req_addr), .req_wdata(req_wdata),
		.serialize(serialize), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
		.req_ready(req_ready), .load_done(load_done), .load_data(load_data),
		.fetch_allow(fetch_allow), .mem_valid(mem_valid), .mem_write(mem_write),
		.mem_to_main(mem_to_main), .mem_type(mem_type), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .line_valid(line_valid), .line_addr(line_addr),
		.line_data(line_data), .line_mask(line_mask));
	mem_model i_mem (.clk(clk), .rstn(rstn), .slow(slow), .mem_valid(mem_valid),
		.line_valid(line_valid), .mem_addr(mem_addr), .mem_ready(mem_ready),
		.mem_rdata(mem_rdata));
	// ==========
	// Clock, watchdog and transfer log
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		test_done;
	end
	always @(posedge clk)
	begin
		if (mem_valid && mem_ready)
			q.push_back({1'b0, mem_addr[15:0], mem_write ? mem_wdata : 8'h00});
		if (line_valid && mem_ready)
		begin
			q.push_back({1'b1, line_addr[15:0], 8'h00});
			ln_data <= line_data;
			ln_mask <= line_mask;
		end
	end
	// ==========
	// Shared tasks
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Request held until taken at an edge with req_ready high
	task req(input logic [2:0] op, input logic [2:0] ty, input logic [31:0] a, input logic [7:0] d);
		@(posedge clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_type <= ty;
		req_addr <= a;
		req_wdata <= d;
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
	endtask
	task drain;
		repeat (3) @(posedge clk);
		do @(posedge clk); while (fetch_allow !== 1'b1);
		repeat (2) @(posedge clk);
	endtask
	task pop(input logic [24:0] e);
		chk(q.size() ? q.pop_front() : 25'h1FFFFFF, e);
	endtask
	task test_done;
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========
	// Scenarios
	task t_order;
		req(`OP_STORE, `MT_WRITEBACK, 32'h10, 8'h01);
		req(`OP_STORE, `MT_WRITEBACK, 32'h20, 8'h02);
		req(`OP_STORE, `MT_WRITEBACK, 32'h30, 8'h03);
		req(`OP_STORE_FENCE, `MT_WRITEBACK, 32'h0, 8'h00);
		drain;
		pop({1'b0, 16'h0010, 8'h01});
		pop({1'b0, 16'h0020, 8'h02});
		pop({1'b0, 16'h0030, 8'h03});
	endtask
	// Slow memory keeps the store buffered when the load arrives
	task t_fwd;
		slow <= 1'b1;
		req(`OP_STORE, `MT_WRITEBACK, 32'h40, 8'h5A);
		req(`OP_LOAD, `MT_WRITEBACK, 32'h40, 8'h00);
		do @(posedge clk); while (load_done !== 1'b1);
		chk(load_data, 8'h5A);
		drain;
		pop({1'b0, 16'h0040, 8'h5A});
	endtask
	task t_comb;
		req(`OP_STORE, `MT_COMBINING, 32'h1003, 8'h11);
		req(`OP_STORE, `MT_COMBINING, 32'h1000, 8'h22);
		req(`OP_STORE, `MT_COMBINING, 32'h1003, 8'h33);
		req(`OP_STORE_FENCE, `MT_WRITEBACK, 32'h0, 8'h00);
		drain;
		pop({1'b1, 16'h1000, 8'h00});
		chk(ln_mask, 64'h9);
		chk(ln_data[31:0] & 32'hFF0000FF, 32'h33000022);
	endtask
	// Leaving the range, then a plain store hitting the new range
	task t_range;
		req(`OP_STORE, `MT_COMBINING, 32'h2005, 8'h44);
		req(`OP_STORE, `MT_COMBINING, 32'h3001, 8'h55);
		req(`OP_STORE, `MT_WRITEBACK, 32'h3002, 8'h66);
		req(`OP_STORE_FENCE, `MT_WRITEBACK, 32'h0, 8'h00);
		drain;
		pop({1'b1, 16'h2000, 8'h00});
		pop({1'b1, 16'h3000, 8'h00});
		chk(ln_mask, 64'h2);
		pop({1'b0, 16'h3002, 8'h66});
	endtask
	// Port access, atomic and uncached load each flush the line first
	task t_events;
		logic [2:0] ops[3];
		logic [24:0] e;
		ops = '{`OP_PORT_IO, `OP_ATOMIC, `OP_LOAD};
		slow <= 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			req(`OP_STORE, `MT_COMBINING, 32'h4000 + k, 8'h08);
			req(ops[k], `MT_UNCACHED, 32'h60, 8'h77);
			drain;
			pop({1'b1, 16'h4000, 8'h00});
			e = q.size() ? q.pop_front() : 25'h0;
			chk(e[24:8], {1'b0, 16'h0060});
		end
	endtask
	task t_serial;
		slow <= 1'b1;
		req(`OP_STORE, `MT_WRITEBACK, 32'h70, 8'h07);
		req(`OP_STORE, `MT_COMBINING, 32'h5000, 8'h09);
		serialize <= 1'b1;
		@(posedge clk);
		do @(posedge clk); while (fetch_allow !== 1'b1);
		chk(q.size(), 2);
		serialize <= 1'b0;
		drain;
		q.delete();
	endtask
	initial
	begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req_op = 3'h0;
		req_type = 3'h0;
		req_addr = 32'h0;
		req_wdata = 8'h00;
		serialize = 1'b0;
		slow = 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		t_order;
		t_fwd;
		t_comb;
		t_range;
		t_events;
		t_serial;
		test_done;
	end
endmodule // store_buffer_write_combining_test
`default_nettype wire
